// File: design/gpio_cfg_pkg.sv
// Purpose: shared constants and types for the remote capable pin configuration block
// Assumes: Avalon-MM word addressing, register index equals word address
// Notes: slice order inside a byte is value, remote, direction, enable
package gpio_cfg_pkg;

  // ==========================================================
  // bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned LANE0 = 0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PINS_ONE_TWO = 8'h1e;
  localparam logic [7:0] IDX_PIN_THREE = 8'h1f;
  localparam logic [7:0] IDX_PINS_FIVE_SIX = 8'h20;
  localparam logic [7:0] IDX_PORT_CTRL = 8'h30;
  localparam logic [7:0] IDX_PIN_STATUS = 8'h31;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] SLICE_RESET = 4'h0;
  localparam int unsigned PORT_SEL_BIT = 0;

  // ==========================================================
  // slice layout
  localparam int unsigned SLICE_W = 4;
  localparam int unsigned LOW_SLICE_LSB = 0;
  localparam int unsigned HIGH_SLICE_LSB = 4;
  localparam int unsigned BIT_OUT_VALUE = 3;
  localparam int unsigned BIT_REMOTE = 2;
  localparam int unsigned BIT_DIR = 1;
  localparam int unsigned BIT_EN = 0;
  // parked slice: tri-state, no remote control
  localparam logic [3:0] SLICE_PARKED = 4'h2;

  // pad code is {direction, enable}
  typedef enum logic [1:0] {
    MODE_FUNCTIONAL = 2'b00,
    MODE_GPIO_OUT = 2'b01,
    MODE_TRISTATE = 2'b10,
    MODE_GPIO_IN = 2'b11
  } pad_mode_e;

  // ==========================================================
  // pads and slices
  localparam int unsigned PAD_COUNT = 8;
  localparam int unsigned SLICE_COUNT = 5;
  localparam int unsigned SEC_COUNT = 3;
  localparam int unsigned PAD_P1 = 0;
  localparam int unsigned PAD_P2 = 1;
  localparam int unsigned PAD_P3 = 2;
  localparam int unsigned PAD_P5 = 3;
  localparam int unsigned PAD_P6 = 4;
  localparam int unsigned PAD_S1 = 5;
  localparam int unsigned PAD_S2 = 6;
  localparam int unsigned PAD_S3 = 7;
  localparam int unsigned SL_1 = 0;
  localparam int unsigned SL_2 = 1;
  localparam int unsigned SL_3 = 2;
  localparam int unsigned SL_5 = 3;
  localparam int unsigned SL_6 = 4;
  localparam logic [7:0] OE_N_IDLE = 8'hff;
  localparam logic [7:0] PAD_LOW = 8'h00;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_e;

endpackage

// File: design/pad_ctrl_if.sv
// Purpose: carrier between register logic and pad mode decoder
// Assumes: one clock domain, purely combinational decode
// Notes: drive_en high means the pad is driven
`timescale 1ns/10ps
interface pad_ctrl_if;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0][gpio_cfg_pkg::SLICE_W-1:0] slice;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0] remote_value;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0] func_value;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0] drive_value;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0] drive_en;

  modport cfg (
    output slice,
    output remote_value,
    output func_value,
    input drive_value,
    input drive_en
  );

  modport dec (
    input slice,
    input remote_value,
    input func_value,
    output drive_value,
    output drive_en
  );
endinterface

// File: design/pad_mode_decoder.sv
// Purpose: turn each pad's four-bit slice into drive value and drive enable
// Assumes: slices already routed to the pad that owns them
// Notes: remote control outranks the local pad code
`timescale 1ns/10ps
module pad_mode_decoder (
  pad_ctrl_if.dec pads
);

  // ==========================================================
  // per pad decode
  for (genvar i = 0; i < gpio_cfg_pkg::PAD_COUNT; i++) begin : g_pad
    gpio_cfg_pkg::pad_mode_e mode;
    logic drv;
    logic en;

    assign mode = gpio_cfg_pkg::pad_mode_e'({pads.slice[i][gpio_cfg_pkg::BIT_DIR],
                                              pads.slice[i][gpio_cfg_pkg::BIT_EN]});

    always_comb begin
      drv = 1'b0;
      en = 1'b0;
      if (pads.slice[i][gpio_cfg_pkg::BIT_REMOTE]) begin
        // remote serializer owns the pin, forced output
        drv = pads.remote_value[i]; // RULE3
        en = 1'b1; // RULE3
      end else begin
        unique case (mode)
          gpio_cfg_pkg::MODE_FUNCTIONAL: begin
            drv = pads.func_value[i]; // RULE4
            en = 1'b1; // RULE4
          end
          gpio_cfg_pkg::MODE_GPIO_OUT: begin
            drv = pads.slice[i][gpio_cfg_pkg::BIT_OUT_VALUE]; // RULE2 RULE5
            en = 1'b1; // RULE5
          end
          gpio_cfg_pkg::MODE_TRISTATE: begin
            en = 1'b0; // RULE4
          end
          gpio_cfg_pkg::MODE_GPIO_IN: begin
            en = 1'b0; // RULE6
          end
        endcase
      end
    end

    assign pads.drive_value[i] = drv;
    assign pads.drive_en[i] = en;
  end

endmodule

// File: design/remote_capable_gpio_config.sv
// Purpose: configuration and output control for pins 1, 2, 3, 5, 6 and secondary 1 to 3
// Assumes: remote and functional values come from logic on clock_in
// Notes: pad outputs are registered, so a setting reaches the pins one edge later
// Function
// (RULE1) port select moves slices 1-3 to secondary pins
// (RULE2) local value driven only in gpio output
// (RULE3) remote enable forces output of remote value
// (RULE4) code 00 functional output, 10 tri-state
// (RULE5) code 01 drives general-purpose output
// (RULE6) code 11 makes pad an input
// (RULE7) register 1Eh holds pin 2 and 1
// (RULE8) register 1Fh holds pin 3, upper reserved
// (RULE9) register 20h holds pin 6 and 5
`timescale 1ns/10ps
module remote_capable_gpio_config (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [gpio_cfg_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [gpio_cfg_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [gpio_cfg_pkg::BE_W-1:0] avs_byteenable_in,
  output logic [gpio_cfg_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [gpio_cfg_pkg::SLICE_COUNT-1:0] remote_value_in,
  input wire logic [gpio_cfg_pkg::PAD_COUNT-1:0] func_value_in,
  input wire logic [gpio_cfg_pkg::PAD_COUNT-1:0] pad_in,
  output logic [gpio_cfg_pkg::PAD_COUNT-1:0] pad_out,
  output logic [gpio_cfg_pkg::PAD_COUNT-1:0] pad_oe_n_out
);

  // ==========================================================
  // declarations
  gpio_cfg_pkg::bus_state_e bus_state;
  logic [7:0] pins_one_two_config;
  logic [3:0] pin_three_config;
  logic [7:0] pins_five_six_config;
  logic secondary_port_select;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0] pad_sync_a;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0] pad_sync_b;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0] pad_sync_c;
  logic [gpio_cfg_pkg::PAD_COUNT-1:0] pin_level;
  logic [gpio_cfg_pkg::SLICE_COUNT-1:0][gpio_cfg_pkg::SLICE_W-1:0] slice_cfg;
  logic [gpio_cfg_pkg::DATA_W-1:0] next_readdata;
  logic request;
  logic commit;
  logic lane0_write;

  pad_ctrl_if pads ();

  // ==========================================================
  // bus handshake
  // every access takes exactly one wait cycle; waitrequest is a flop
  assign request = avs_read_in || avs_write_in;
  assign commit = (bus_state == gpio_cfg_pkg::BUS_ANSWER) && request;
  assign lane0_write = commit && avs_write_in && avs_byteenable_in[gpio_cfg_pkg::LANE0];

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bus_state <= gpio_cfg_pkg::BUS_IDLE;
      avs_waitrequest_out <= 1'b1;
    end else begin
      unique case (bus_state)
        gpio_cfg_pkg::BUS_IDLE: begin
          if (request) begin
            bus_state <= gpio_cfg_pkg::BUS_ANSWER;
            avs_waitrequest_out <= 1'b0;
          end
        end
        gpio_cfg_pkg::BUS_ANSWER: begin
          bus_state <= gpio_cfg_pkg::BUS_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    next_readdata = gpio_cfg_pkg::READ_ZERO;
    unique case (avs_address_in)
      gpio_cfg_pkg::IDX_PINS_ONE_TWO: next_readdata[7:0] = pins_one_two_config; // RULE7
      gpio_cfg_pkg::IDX_PIN_THREE: next_readdata[3:0] = pin_three_config; // RULE8
      gpio_cfg_pkg::IDX_PINS_FIVE_SIX: next_readdata[7:0] = pins_five_six_config; // RULE9
      gpio_cfg_pkg::IDX_PORT_CTRL:
        next_readdata[gpio_cfg_pkg::PORT_SEL_BIT] = secondary_port_select; // RULE1
      gpio_cfg_pkg::IDX_PIN_STATUS: next_readdata[7:0] = pin_level;
      default: next_readdata = gpio_cfg_pkg::READ_ZERO;
    endcase
  end

  // data is captured in the wait cycle, so it stands at the answering edge
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      avs_readdata_out <= gpio_cfg_pkg::READ_ZERO;
    end else if (bus_state == gpio_cfg_pkg::BUS_IDLE && avs_read_in) begin
      avs_readdata_out <= next_readdata;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pins_one_two_config <= gpio_cfg_pkg::CFG_RESET; // RULE7
      pin_three_config <= gpio_cfg_pkg::SLICE_RESET; // RULE8
      pins_five_six_config <= gpio_cfg_pkg::CFG_RESET; // RULE9
    end else if (lane0_write) begin
      unique case (avs_address_in)
        gpio_cfg_pkg::IDX_PINS_ONE_TWO: pins_one_two_config <= avs_writedata_in[7:0]; // RULE7
        // upper nibble has no pin behind it, writes there are dropped
        gpio_cfg_pkg::IDX_PIN_THREE: pin_three_config <= avs_writedata_in[3:0]; // RULE8
        gpio_cfg_pkg::IDX_PINS_FIVE_SIX: pins_five_six_config <= avs_writedata_in[7:0]; // RULE9
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      secondary_port_select <= 1'b0;
    end else if (lane0_write && avs_address_in == gpio_cfg_pkg::IDX_PORT_CTRL) begin
      secondary_port_select <= avs_writedata_in[gpio_cfg_pkg::PORT_SEL_BIT];
    end
  end

  // ==========================================================
  // pad input synchroniser
  // level moves only when the second and third stages agree
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pad_sync_a <= gpio_cfg_pkg::PAD_LOW;
      pad_sync_b <= gpio_cfg_pkg::PAD_LOW;
      pad_sync_c <= gpio_cfg_pkg::PAD_LOW;
    end else begin
      pad_sync_a <= pad_in;
      pad_sync_b <= pad_sync_a;
      pad_sync_c <= pad_sync_b;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_level <= gpio_cfg_pkg::PAD_LOW;
    end else begin
      pin_level <= (pad_sync_b & pad_sync_c) | (pin_level & (pad_sync_b | pad_sync_c));
    end
  end

  // ==========================================================
  // slice routing
  assign slice_cfg[gpio_cfg_pkg::SL_1] =
    pins_one_two_config[gpio_cfg_pkg::LOW_SLICE_LSB +: gpio_cfg_pkg::SLICE_W];
  assign slice_cfg[gpio_cfg_pkg::SL_2] =
    pins_one_two_config[gpio_cfg_pkg::HIGH_SLICE_LSB +: gpio_cfg_pkg::SLICE_W];
  assign slice_cfg[gpio_cfg_pkg::SL_3] = pin_three_config;
  assign slice_cfg[gpio_cfg_pkg::SL_5] =
    pins_five_six_config[gpio_cfg_pkg::LOW_SLICE_LSB +: gpio_cfg_pkg::SLICE_W];
  assign slice_cfg[gpio_cfg_pkg::SL_6] =
    pins_five_six_config[gpio_cfg_pkg::HIGH_SLICE_LSB +: gpio_cfg_pkg::SLICE_W];

  // the unselected port of pins 1-3 is parked in tri-state
  for (genvar k = 0; k < gpio_cfg_pkg::SEC_COUNT; k++) begin : g_route
    assign pads.slice[gpio_cfg_pkg::PAD_P1 + k] = secondary_port_select ?
      gpio_cfg_pkg::SLICE_PARKED : slice_cfg[gpio_cfg_pkg::SL_1 + k]; // RULE1
    assign pads.slice[gpio_cfg_pkg::PAD_S1 + k] = secondary_port_select ?
      slice_cfg[gpio_cfg_pkg::SL_1 + k] : gpio_cfg_pkg::SLICE_PARKED; // RULE1
  end
  assign pads.slice[gpio_cfg_pkg::PAD_P5] = slice_cfg[gpio_cfg_pkg::SL_5];
  assign pads.slice[gpio_cfg_pkg::PAD_P6] = slice_cfg[gpio_cfg_pkg::SL_6];
  assign pads.remote_value = {remote_value_in[gpio_cfg_pkg::SEC_COUNT-1:0], remote_value_in};
  assign pads.func_value = func_value_in;

  pad_mode_decoder u_decoder (
    .pads(pads.dec)
  );

  // ==========================================================
  // registered pad drive
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pad_out <= gpio_cfg_pkg::PAD_LOW;
      pad_oe_n_out <= gpio_cfg_pkg::OE_N_IDLE;
    end else begin
      pad_out <= pads.drive_value & pads.drive_en; // RULE2
      pad_oe_n_out <= ~pads.drive_en; // RULE4
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  property p_secondary_swap;
    secondary_port_select && !slice_cfg[gpio_cfg_pkg::SL_1][gpio_cfg_pkg::BIT_REMOTE] &&
      slice_cfg[gpio_cfg_pkg::SL_1][1:0] == gpio_cfg_pkg::MODE_GPIO_OUT |=>
      !pad_oe_n_out[gpio_cfg_pkg::PAD_S1] && pad_oe_n_out[gpio_cfg_pkg::PAD_P1] &&
      pad_out[gpio_cfg_pkg::PAD_S1] ==
        $past(slice_cfg[gpio_cfg_pkg::SL_1][gpio_cfg_pkg::BIT_OUT_VALUE]);
  endproperty
  a_secondary_swap: assert property (p_secondary_swap) // RULE1
    else $error("secondary pin 1 not driven from slice 1");

  property p_secondary_parked;
    !secondary_port_select |=> pad_oe_n_out[gpio_cfg_pkg::PAD_S3:gpio_cfg_pkg::PAD_S1] == 3'h7;
  endproperty
  a_secondary_parked: assert property (p_secondary_parked) // RULE1
    else $error("secondary pins driven while primary port selected");

  property p_local_value;
    !slice_cfg[gpio_cfg_pkg::SL_5][gpio_cfg_pkg::BIT_REMOTE] &&
      slice_cfg[gpio_cfg_pkg::SL_5][1:0] != gpio_cfg_pkg::MODE_GPIO_OUT |=>
      pad_out[gpio_cfg_pkg::PAD_P5] !=
        $past(slice_cfg[gpio_cfg_pkg::SL_5][gpio_cfg_pkg::BIT_OUT_VALUE]) ||
      pad_out[gpio_cfg_pkg::PAD_P5] == $past(func_value_in[gpio_cfg_pkg::PAD_P5]) ||
      !pad_out[gpio_cfg_pkg::PAD_P5];
  endproperty
  a_local_value: assert property (p_local_value) // RULE2
    else $error("pin 5 shows local value outside gpio output mode");

  property p_remote_drive;
    slice_cfg[gpio_cfg_pkg::SL_6][gpio_cfg_pkg::BIT_REMOTE] |=>
      !pad_oe_n_out[gpio_cfg_pkg::PAD_P6] &&
      pad_out[gpio_cfg_pkg::PAD_P6] == $past(remote_value_in[gpio_cfg_pkg::SL_6]);
  endproperty
  a_remote_drive: assert property (p_remote_drive) // RULE3
    else $error("pin 6 not driven with remote value");

  property p_functional_and_tristate;
    !slice_cfg[gpio_cfg_pkg::SL_5][gpio_cfg_pkg::BIT_REMOTE] |=>
      ($past(slice_cfg[gpio_cfg_pkg::SL_5][1:0]) == gpio_cfg_pkg::MODE_FUNCTIONAL) ==
        (!pad_oe_n_out[gpio_cfg_pkg::PAD_P5] &&
         pad_out[gpio_cfg_pkg::PAD_P5] == $past(func_value_in[gpio_cfg_pkg::PAD_P5])) ||
      $past(slice_cfg[gpio_cfg_pkg::SL_5][1:0]) == gpio_cfg_pkg::MODE_GPIO_OUT;
  endproperty
  a_functional_and_tristate: assert property (p_functional_and_tristate) // RULE4
    else $error("pin 5 functional or tri-state decode wrong");

  property p_tristate;
    !slice_cfg[gpio_cfg_pkg::SL_5][gpio_cfg_pkg::BIT_REMOTE] &&
      slice_cfg[gpio_cfg_pkg::SL_5][1:0] == gpio_cfg_pkg::MODE_TRISTATE |=>
      pad_oe_n_out[gpio_cfg_pkg::PAD_P5] && !pad_out[gpio_cfg_pkg::PAD_P5];
  endproperty
  a_tristate: assert property (p_tristate) // RULE4
    else $error("pin 5 driven in tri-state code");

  property p_gpio_out;
    !secondary_port_select && !slice_cfg[gpio_cfg_pkg::SL_2][gpio_cfg_pkg::BIT_REMOTE] &&
      slice_cfg[gpio_cfg_pkg::SL_2][1:0] == gpio_cfg_pkg::MODE_GPIO_OUT |=>
      !pad_oe_n_out[gpio_cfg_pkg::PAD_P2] &&
      pad_out[gpio_cfg_pkg::PAD_P2] ==
        $past(slice_cfg[gpio_cfg_pkg::SL_2][gpio_cfg_pkg::BIT_OUT_VALUE]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) // RULE5
    else $error("pin 2 not driven as gpio output");

  property p_gpio_in;
    !secondary_port_select && !slice_cfg[gpio_cfg_pkg::SL_3][gpio_cfg_pkg::BIT_REMOTE] &&
      slice_cfg[gpio_cfg_pkg::SL_3][1:0] == gpio_cfg_pkg::MODE_GPIO_IN |=>
      pad_oe_n_out[gpio_cfg_pkg::PAD_P3];
  endproperty
  a_gpio_in: assert property (p_gpio_in) // RULE6
    else $error("pin 3 driven while configured as input");

  property p_write_one_two;
    avs_write_in && !avs_waitrequest_out && avs_byteenable_in[gpio_cfg_pkg::LANE0] &&
      avs_address_in == gpio_cfg_pkg::IDX_PINS_ONE_TWO |=>
      pins_one_two_config == $past(avs_writedata_in[7:0]);
  endproperty
  a_write_one_two: assert property (p_write_one_two) // RULE7
    else $error("pins one two register did not take write");

  property p_read_three;
    avs_read_in && !avs_waitrequest_out && avs_address_in == gpio_cfg_pkg::IDX_PIN_THREE |->
      avs_readdata_out == {28'h0000000, pin_three_config};
  endproperty
  a_read_three: assert property (p_read_three) // RULE8
    else $error("pin three register read wrong or reserved bits set");

  property p_write_five_six;
    avs_write_in && !avs_waitrequest_out && avs_byteenable_in[gpio_cfg_pkg::LANE0] &&
      avs_address_in == gpio_cfg_pkg::IDX_PINS_FIVE_SIX |=>
      pins_five_six_config == $past(avs_writedata_in[7:0]);
  endproperty
  a_write_five_six: assert property (p_write_five_six) // RULE9
    else $error("pins five six register did not take write");

  property p_one_wait;
    request && avs_waitrequest_out && bus_state == gpio_cfg_pkg::BUS_IDLE |=>
      !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("answer not given after exactly one wait cycle");

  c_remote: cover property (slice_cfg[gpio_cfg_pkg::SL_6][gpio_cfg_pkg::BIT_REMOTE] ##1
                            !pad_oe_n_out[gpio_cfg_pkg::PAD_P6]);
  c_swap: cover property ($rose(secondary_port_select) ##1
                          !pad_oe_n_out[gpio_cfg_pkg::PAD_S1]);
  c_input: cover property (slice_cfg[gpio_cfg_pkg::SL_3][1:0] == gpio_cfg_pkg::MODE_GPIO_IN);
  c_write: cover property (lane0_write && avs_address_in == gpio_cfg_pkg::IDX_PINS_FIVE_SIX);

endmodule

// File: tb/remote_serializer_model.sv
// Purpose: stand-in for the remote serializer feeding received pin values
// Assumes: values cross the link as a plain delay line on clock_in
// Notes: lag_in picks how many extra cycles the link takes (0 is prompt)
`timescale 1ns/10ps
module remote_serializer_model (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [4:0] send_value_in,
  input wire logic [2:0] lag_in,
  output logic [4:0] remote_value_out
);
  // ==========================================================
  // link delay line
  logic [4:0] pipe [0:7];

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < 8; i++) pipe[i] <= 5'h00;
    end else begin
      pipe[0] <= send_value_in;
      for (int i = 1; i < 8; i++) pipe[i] <= pipe[i-1];
    end
  end

  // a slow link shows stale values until the new ones arrive
  assign remote_value_out = pipe[lag_in];
endmodule

// File: tb/test_remote_capable_gpio_config.sv
// Purpose: self-checking bench for the remote capable pin configuration block
// Assumes: Avalon-MM word addressing, registered pads one edge after a write lands
// Notes: expected pads come from the bench's own copy of the slices
`timescale 1ns/10ps
module test_remote_capable_gpio_config;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0] avs_byteenable_in = 4'h1;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [4:0] remote_value_in;
  logic [7:0] func_value_in = 8'hb6;
  logic [7:0] pad_in = 8'h3c;
  logic [7:0] pad_out;
  logic [7:0] pad_oe_n_out;
  logic [4:0] send_value = 5'h00;
  logic [2:0] lag = 3'h0;
  logic [3:0] sl [5];
  logic psel = 1'b0;
  logic [31:0] rd;
  int num_errors = 0;
  int checks = 0;

  always #20 clock_in = ~clock_in;

  remote_capable_gpio_config DUT (
    .clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .remote_value_in(remote_value_in), .func_value_in(func_value_in), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n_out(pad_oe_n_out)
  );

  remote_serializer_model link (
    .clock_in(clock_in), .resetn_in(resetn_in), .send_value_in(send_value),
    .lag_in(lag), .remote_value_out(remote_value_in)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one access; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] data,
                     input logic [3:0] be);
    int n;
    logic w;
    @(posedge clock_in);
    avs_address_in <= idx;
    avs_writedata_in <= {24'h00_0000, data};
    avs_byteenable_in <= be;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    n = 0;
    do begin
      #1;
      w = avs_waitrequest_out;
      rd = avs_readdata_out;
      @(posedge clock_in);
      n++;
    end while (w !== 1'b0 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'h1);
    chk(rd, {24'h00_0000, exp});
  endtask

  task automatic apply_cfg();
    bus(1'b1, gpio_cfg_pkg::IDX_PINS_ONE_TWO, {sl[1], sl[0]}, 4'h1);
    bus(1'b1, gpio_cfg_pkg::IDX_PIN_THREE, {4'h0, sl[2]}, 4'h1);
    bus(1'b1, gpio_cfg_pkg::IDX_PINS_FIVE_SIX, {sl[4], sl[3]}, 4'h1);
  endtask

  // expected {oe_n, value} of all eight pads from the bench's slices
  task automatic chk_pads();
    logic [7:0] oe;
    logic [7:0] o;
    int pad;
    oe = 8'hff;
    o = 8'h00;
    @(posedge clock_in);
    #1;
    for (int k = 0; k < 5; k++) begin
      pad = (psel && k < 3) ? k + 5 : k;
      if (sl[k][2]) begin
        oe[pad] = 1'b0;
        o[pad] = remote_value_in[k];
      end else if (sl[k][1:0] == 2'b00) begin
        oe[pad] = 1'b0;
        o[pad] = func_value_in[pad];
      end else if (sl[k][1:0] == 2'b01) begin
        oe[pad] = 1'b0;
        o[pad] = sl[k][3];
      end
      // codes 10 and 11 leave the pad undriven
    end
    chk({24'h0, pad_oe_n_out}, {24'h0, oe});
    chk({24'h0, pad_out}, {24'h0, o});
  endtask

  task automatic set_all(input logic [3:0] s);
    for (int k = 0; k < 5; k++) sl[k] = s;
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset();
    rd_chk(gpio_cfg_pkg::IDX_PINS_ONE_TWO, 8'h00);
    rd_chk(gpio_cfg_pkg::IDX_PIN_THREE, 8'h00);
    rd_chk(gpio_cfg_pkg::IDX_PINS_FIVE_SIX, 8'h00);
    rd_chk(gpio_cfg_pkg::IDX_PORT_CTRL, 8'h00);
    set_all(4'h0);
    chk_pads();
    $display("test_reset done");
  endtask

  task automatic test_regs();
    bus(1'b1, gpio_cfg_pkg::IDX_PINS_ONE_TWO, 8'ha5, 4'h1);
    rd_chk(gpio_cfg_pkg::IDX_PINS_ONE_TWO, 8'ha5);
    bus(1'b1, gpio_cfg_pkg::IDX_PINS_ONE_TWO, 8'h3c, 4'he);
    rd_chk(gpio_cfg_pkg::IDX_PINS_ONE_TWO, 8'ha5);
    bus(1'b1, gpio_cfg_pkg::IDX_PIN_THREE, 8'hff, 4'h1);
    rd_chk(gpio_cfg_pkg::IDX_PIN_THREE, 8'h0f);
    bus(1'b1, gpio_cfg_pkg::IDX_PINS_FIVE_SIX, 8'hc3, 4'h1);
    rd_chk(gpio_cfg_pkg::IDX_PINS_FIVE_SIX, 8'hc3);
    bus(1'b1, 8'h05, 8'h77, 4'h1);
    rd_chk(8'h05, 8'h00);
    rd_chk(gpio_cfg_pkg::IDX_PIN_STATUS, 8'h3c);
    // new level must pass the synchroniser before the status shows it
    @(posedge clock_in);
    pad_in <= 8'hc3;
    repeat (4) @(posedge clock_in);
    rd_chk(gpio_cfg_pkg::IDX_PIN_STATUS, 8'hc3);
    $display("test_regs done");
  endtask

  // every pad code with both local values, and func value flipped
  task automatic test_codes();
    for (int c = 0; c < 8; c++) begin
      set_all({c[2], 1'b0, c[1:0]});
      apply_cfg();
      chk_pads();
      @(posedge clock_in);
      func_value_in <= ~func_value_in;
      chk_pads();
    end
    $display("test_codes done");
  endtask

  // remote control beats tri-state and input codes, prompt and slow link
  task automatic test_remote();
    sl[0] = 4'h6;
    sl[1] = 4'h7;
    sl[2] = 4'h4;
    sl[3] = 4'hd;
    sl[4] = 4'h5;
    send_value <= 5'h15;
    apply_cfg();
    chk_pads();
    lag <= 3'h5;
    send_value <= 5'h0a;
    repeat (8) @(posedge clock_in);
    chk_pads();
    $display("test_remote done");
  endtask

  task automatic test_port_sel();
    bus(1'b1, gpio_cfg_pkg::IDX_PORT_CTRL, 8'h01, 4'h1);
    psel = 1'b1;
    for (int c = 0; c < 4; c++) begin
      sl[0] = {1'b1, 1'b0, c[1:0]};
      sl[1] = 4'h5;
      sl[2] = {c[0], 1'b0, 2'b01};
      apply_cfg();
      chk_pads();
    end
    bus(1'b1, gpio_cfg_pkg::IDX_PORT_CTRL, 8'h00, 4'h1);
    psel = 1'b0;
    chk_pads();
    $display("test_port_sel done");
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    test_reset();
    test_regs();
    test_codes();
    test_remote();
    test_port_sel();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clock_in);
    num_errors++;
    test_done();
  end
endmodule
